// >>> vspb_config.sv
// Double-buffered register set of the second video sprite plane
// Operation
// - Bit 28 enables excess-512 on bypass path
// - Bit 27 clear expands YUV to full range
// - Bit 26 picks YUV 4:2:2 or BGRX
// - Source key makes matching pixels transparent
// - Bits 21:20 select pixel and line duplication
// - Bit 19 bypasses YUV to RGB conversion
// - Bit 18 picks BT.601 or BT.709 matrix
// - Bits 17:16 give YUV 4:2:2 byte order
// - Bit 15 rotates plane by 180 degrees
// - Bit 10 selects tiled or linear surface
// - Destination key shows sprite where pipe matches
// - Linear offset added to base, vblank loaded
// - Stride first, surface write triggers both
// - Position fields load on vblank rising edge
// - Duplication doubles coordinates and size
// - Size holds height and width minus one
// - Key value bytes are minimums or exact
// - Mask gates dest bits, enables source channels
// - Trigger write arms control update at vblank
// - Enable bit follows staged value each vblank
`timescale 1ns/1ns
`default_nettype none
module vspb_config
  import vspb_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [VSPB_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic surf_write,
  input wire logic [31:0] surf_base,
  input wire logic [23:0] key_max,
  input wire logic vblank,
  input wire logic [31:0] sprite_word,
  input wire logic sprite_odd,
  input wire logic [23:0] pipe_pixel,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic [31:0] active_control,
  output logic [31:0] active_stride,
  output logic [31:0] active_key_value,
  output logic [31:0] active_key_mask,
  output logic [12:0] eff_x,
  output logic [12:0] eff_y,
  output logic [12:0] eff_w,
  output logic [12:0] eff_h,
  output logic [31:0] first_pixel_addr,
  output logic line_repeat,
  output logic scan_reverse,
  output logic [29:0] pixel_10b,
  output logic use_sprite,
  output logic csc_on,
  output logic range_expand,
  output logic matrix_709,
  output logic update_pending,
  output logic plane_enabled
);
  typedef struct packed {
    logic [31:0] s_ctl, s_off, s_stride, s_pos, s_size, s_kval, s_kmsk;
    logic [31:0] a_ctl, a_off, a_stride, a_pos, a_size, a_kval, a_kmsk;
    logic pending;
    logic vb_d;
    logic [31:0] rdata;
    logic rvalid;
    logic [12:0] ex, ey, ew, eh;
    logic [31:0] faddr;
    logic line_rep;
    logic scan_rev;
    logic [29:0] pix10;
    logic use_spr;
    logic csc;
    logic rng;
    logic m709;
  } vspb_state_t;

  vspb_state_t st;
  vspb_state_t next_st;
  logic vb_edge;
  logic trig;
  vspb_cfg_if cfg ();

  // Active set feeds the pixel and geometry logic
  assign cfg.ctl = st.a_ctl;
  assign cfg.key_val = st.a_kval;
  assign cfg.key_msk = st.a_kmsk;
  assign cfg.key_max = key_max;
  assign cfg.pos = st.a_pos;
  assign cfg.size = st.a_size;
  assign cfg.lin_off = st.a_off;
  assign cfg.surf_base = surf_base;
  assign cfg.spr_word = sprite_word;
  assign cfg.spr_odd = sprite_odd;
  assign cfg.pipe_pix = pipe_pixel;

  vspb_pix u_pix (
    .cfg(cfg.pix)
  );

  vspb_geom u_geom (
    .cfg(cfg.geom)
  );

  // Vblank comes from pipe timing on this clock, so no synchroniser
  assign vb_edge = vblank & ~st.vb_d;
  // surface write, or enable rising through a control write
  assign trig = surf_write | (reg_wr && reg_addr == VSPB_OFF_CTL &&
    reg_wdata[VSPB_EN_BIT] && !st.s_ctl[VSPB_EN_BIT]);

  // Next state: staging writes, vblank commit, reads, registered results
  always_comb begin
    next_st = st;
    next_st.vb_d = vblank;
    if (reg_wr) begin
      case (reg_addr)
        VSPB_OFF_CTL: next_st.s_ctl = reg_wdata & VSPB_MASK_CTL;
        VSPB_OFF_LINOFF: next_st.s_off = reg_wdata & VSPB_MASK_FULL;
        VSPB_OFF_STRIDE: next_st.s_stride = reg_wdata & VSPB_MASK_FULL;
        VSPB_OFF_POS: next_st.s_pos = reg_wdata & VSPB_MASK_CRD;
        VSPB_OFF_SIZE: next_st.s_size = reg_wdata & VSPB_MASK_CRD;
        VSPB_OFF_KVAL: next_st.s_kval = reg_wdata & VSPB_MASK_KVAL;
        VSPB_OFF_KMSK: next_st.s_kmsk = reg_wdata & VSPB_MASK_KMSK;
        default: next_st.s_ctl = st.s_ctl;
      endcase
    end
    if (vb_edge) begin
      // offset, position and size load on every vblank
      next_st.a_off = st.s_off;
      next_st.a_pos = st.s_pos;
      next_st.a_size = st.s_size;
      // disable takes hold without a trigger
      next_st.a_ctl[VSPB_EN_BIT] = st.s_ctl[VSPB_EN_BIT];
      if (st.pending) begin
        next_st.a_ctl = st.s_ctl;
        next_st.a_stride = st.s_stride;
        next_st.a_kval = st.s_kval;
        next_st.a_kmsk = st.s_kmsk;
      end
    end
    // a trigger in the commit cycle stays armed for the next vblank
    next_st.pending = trig | (st.pending & ~vb_edge);
    // Reads show staged values; unmapped addresses return zero
    next_st.rvalid = reg_rd;
    next_st.rdata = VSPB_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        VSPB_OFF_CTL: next_st.rdata = st.s_ctl;
        VSPB_OFF_LINOFF: next_st.rdata = st.s_off;
        VSPB_OFF_STRIDE: next_st.rdata = st.s_stride;
        VSPB_OFF_POS: next_st.rdata = st.s_pos;
        VSPB_OFF_SIZE: next_st.rdata = st.s_size;
        VSPB_OFF_KVAL: next_st.rdata = st.s_kval;
        VSPB_OFF_KMSK: next_st.rdata = st.s_kmsk;
        default: next_st.rdata = VSPB_ZERO;
      endcase
    end
    // geometry and pixel results registered for the pipe
    next_st.ex = cfg.eff_x;
    next_st.ey = cfg.eff_y;
    next_st.ew = cfg.eff_w;
    next_st.eh = cfg.eff_h;
    next_st.faddr = cfg.first_addr;
    next_st.line_rep = cfg.line_rep;
    next_st.scan_rev = cfg.scan_rev;
    next_st.pix10 = cfg.pix10;
    next_st.csc = cfg.csc_on;
    next_st.rng = cfg.range_exp;
    next_st.m709 = cfg.mat_709;
    // destination key wins if software sets both
    next_st.use_spr = st.a_ctl[VSPB_EN_BIT] & (st.a_ctl[VSPB_DSTKEY_BIT] ?
      cfg.dst_hit : ~cfg.src_hit);
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign active_control = st.a_ctl;
  assign active_stride = st.a_stride;
  assign active_key_value = st.a_kval;
  assign active_key_mask = st.a_kmsk;
  assign eff_x = st.ex;
  assign eff_y = st.ey;
  assign eff_w = st.ew;
  assign eff_h = st.eh;
  assign first_pixel_addr = st.faddr;
  assign line_repeat = st.line_rep;
  assign scan_reverse = st.scan_rev;
  assign pixel_10b = st.pix10;
  assign use_sprite = st.use_spr;
  assign csc_on = st.csc;
  assign range_expand = st.rng;
  assign matrix_709 = st.m709;
  assign update_pending = st.pending;
  assign plane_enabled = st.a_ctl[VSPB_EN_BIT];

  // Checks on the commit and key paths
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  pend_set_a: assert property (clk_en && surf_write |=> st.pending)
    else $error("surface write did not arm update");
  commit_a: assert property (clk_en && vb_edge && st.pending |=>
      st.a_ctl == $past(st.s_ctl) && st.a_stride == $past(st.s_stride))
    else $error("armed control set not committed at vblank");
  ctl_hold_a: assert property (clk_en && vb_edge && !st.pending |=>
      st.a_ctl[VSPB_EN_BIT-1:0] == $past(st.a_ctl[VSPB_EN_BIT-1:0]))
    else $error("control changed without trigger");
  en_follow_a: assert property (clk_en && vb_edge |=>
      plane_enabled == $past(st.s_ctl[VSPB_EN_BIT]))
    else $error("enable did not follow staged value");
  pos_load_a: assert property (clk_en && vb_edge |=>
      st.a_pos == $past(st.s_pos) && st.a_size == $past(st.s_size))
    else $error("position or size not loaded at vblank");
  off_hold_a: assert property (clk_en && !vb_edge |=> $stable(st.a_off))
    else $error("offset changed outside vblank");
  addr_lin_a: assert property (clk_en && !st.a_ctl[VSPB_TILED_BIT] |=>
      first_pixel_addr == $past(surf_base) + $past(st.a_off))
    else $error("linear first pixel address wrong");
  addr_tile_a: assert property (clk_en && st.a_ctl[VSPB_TILED_BIT] |=>
      first_pixel_addr == $past(surf_base))
    else $error("tiled address used the linear offset");
  dbl_pix_a: assert property (clk_en &&
      st.a_ctl[VSPB_DUP_LSB +: 2] == VSPB_DUP_PIX |=>
      eff_w == {$past(st.a_size[VSPB_X_LSB +: VSPB_CRD_W]), 1'h1} &&
      eff_h == {1'h0, $past(st.a_size[VSPB_Y_LSB +: VSPB_CRD_W])})
    else $error("pixel doubling size wrong");
  dst_key_a: assert property (clk_en && st.a_ctl[VSPB_EN_BIT] &&
      st.a_ctl[VSPB_DSTKEY_BIT] |=> use_sprite == $past(cfg.dst_hit))
    else $error("destination key select wrong");
  src_key_a: assert property (clk_en && st.a_ctl[VSPB_SRCKEY_BIT] &&
      !st.a_ctl[VSPB_DSTKEY_BIT] && cfg.src_hit |=> !use_sprite)
    else $error("source keyed pixel not transparent");
  rsvd_read_a: assert property (clk_en && reg_rd && reg_addr == VSPB_OFF_CTL |=>
      reg_rvalid && (reg_rdata & ~VSPB_MASK_CTL) == VSPB_ZERO)
    else $error("reserved control bits read nonzero");

  // Conversion flags, widening, duplication and staging masks
  csc_route_a: assert property (clk_en && !st.a_ctl[VSPB_FMT_BIT] &&
      !st.a_ctl[VSPB_CSCOFF_BIT] |=> csc_on)
    else $error("yuv data skipped conversion");
  rgb_dead_a: assert property (clk_en && st.a_ctl[VSPB_FMT_BIT] |=>
      !csc_on && !range_expand && !matrix_709)
    else $error("conversion control live for rgb");
  range_sel_a: assert property (clk_en && !st.a_ctl[VSPB_FMT_BIT] &&
      !st.a_ctl[VSPB_CSCOFF_BIT] |=> range_expand == $past(!st.a_ctl[VSPB_RNGOFF_BIT]))
    else $error("range expansion select wrong");
  fmt_wide_a: assert property (clk_en && st.a_ctl[VSPB_FMT_BIT] |=>
      pixel_10b == {$past(sprite_word[23:16]), VSPB_PAD, $past(sprite_word[15:8]), VSPB_PAD,
      $past(sprite_word[7:0]), VSPB_PAD})
    else $error("test format widening wrong");
  excess_bias_a: assert property (clk_en && st.a_ctl[VSPB_XS512_BIT] &&
      !st.a_ctl[VSPB_FMT_BIT] && st.a_ctl[VSPB_CSCOFF_BIT] &&
      st.a_ctl[VSPB_ORD_LSB +: 2] == VSPB_ORD_YUYV |=>
      pixel_10b[29:22] == {~$past(sprite_word[31]), $past(sprite_word[30:24])})
    else $error("excess-512 chroma bias missing");
  dup_lp_a: assert property (clk_en && st.a_ctl[VSPB_DUP_LSB +: 2] == VSPB_DUP_LP |=>
      eff_y == {$past(st.a_pos[VSPB_Y_LSB +: VSPB_CRD_W]), 1'h0} &&
      eff_h == {$past(st.a_size[VSPB_Y_LSB +: VSPB_CRD_W]), 1'h1})
    else $error("line doubling geometry wrong");
  line_rep_a: assert property (clk_en |=>
      line_repeat == ($past(st.a_ctl[VSPB_DUP_LSB +: 2]) == VSPB_DUP_LP))
    else $error("line repeat wrong");
  scan_rot_a: assert property (clk_en |=> scan_reverse == $past(st.a_ctl[VSPB_ROT_BIT]))
    else $error("rotation flag wrong");
  pos_rsvd_a: assert property (clk_en && reg_wr && reg_addr == VSPB_OFF_POS |=>
      (st.s_pos & ~VSPB_MASK_CRD) == VSPB_ZERO)
    else $error("reserved position bits stored");
  kmsk_rsvd_a: assert property (clk_en && reg_wr && reg_addr == VSPB_OFF_KMSK |=>
      (st.s_kmsk & ~VSPB_MASK_KMSK) == VSPB_ZERO)
    else $error("reserved key mask bits stored");
  key_hold_a: assert property (clk_en && vb_edge && !st.pending |=>
      $stable(st.a_kval) && $stable(st.a_kmsk))
    else $error("key set changed without trigger");

  dst_key_c: cover property (clk_en && st.a_ctl[VSPB_DSTKEY_BIT] && cfg.dst_hit);
  commit_c: cover property (clk_en && vb_edge && st.pending);
  dbl_lp_c: cover property (st.a_ctl[VSPB_DUP_LSB +: 2] == VSPB_DUP_LP);
  src_key_c: cover property (clk_en && cfg.src_hit ##1 !use_sprite);
  retrig_c: cover property (clk_en && vb_edge && trig);
endmodule : vspb_config
`default_nettype wire

// >>> vspb_pkg.sv
// Constants shared by the second sprite plane configuration block
`default_nettype none
package vspb_pkg;
  // Register byte addresses
  localparam int unsigned VSPB_ADDR_W = 20;
  localparam logic [19:0] VSPB_OFF_CTL = 20'h73180;
  localparam logic [19:0] VSPB_OFF_LINOFF = 20'h73184;
  localparam logic [19:0] VSPB_OFF_STRIDE = 20'h73188;
  localparam logic [19:0] VSPB_OFF_POS = 20'h7318C;
  localparam logic [19:0] VSPB_OFF_SIZE = 20'h73190;
  localparam logic [19:0] VSPB_OFF_KVAL = 20'h73194;
  localparam logic [19:0] VSPB_OFF_KMSK = 20'h73198;
  // Writable bit masks; everything else reads as zero
  localparam logic [31:0] VSPB_MASK_CTL = 32'hDC7F8404;
  localparam logic [31:0] VSPB_MASK_FULL = 32'hFFFFFFFF;
  localparam logic [31:0] VSPB_MASK_CRD = 32'h0FFF0FFF;
  localparam logic [31:0] VSPB_MASK_KVAL = 32'h00FFFFFF;
  localparam logic [31:0] VSPB_MASK_KMSK = 32'h07FFFFFF;
  localparam logic [31:0] VSPB_RST = 32'h00000000;
  localparam logic [31:0] VSPB_ZERO = 32'h00000000;
  // Control bit positions
  localparam int unsigned VSPB_EN_BIT = 31;
  localparam int unsigned VSPB_GAMMA_BIT = 30;
  localparam int unsigned VSPB_XS512_BIT = 28;
  localparam int unsigned VSPB_RNGOFF_BIT = 27;
  localparam int unsigned VSPB_FMT_BIT = 26;
  localparam int unsigned VSPB_SRCKEY_BIT = 22;
  localparam int unsigned VSPB_DUP_LSB = 20;
  localparam int unsigned VSPB_CSCOFF_BIT = 19;
  localparam int unsigned VSPB_M709_BIT = 18;
  localparam int unsigned VSPB_ORD_LSB = 16;
  localparam int unsigned VSPB_ROT_BIT = 15;
  localparam int unsigned VSPB_TILED_BIT = 10;
  localparam int unsigned VSPB_DSTKEY_BIT = 2;
  // Duplication and byte order codes
  localparam logic [1:0] VSPB_DUP_NONE = 2'h0;
  localparam logic [1:0] VSPB_DUP_LP = 2'h1;
  localparam logic [1:0] VSPB_DUP_PIX = 2'h3;
  localparam logic [1:0] VSPB_ORD_YUYV = 2'h0;
  localparam logic [1:0] VSPB_ORD_UYVY = 2'h1;
  localparam logic [1:0] VSPB_ORD_YVYU = 2'h2;
  localparam logic [1:0] VSPB_ORD_VYUY = 2'h3;
  // Coordinate and key layouts
  localparam int unsigned VSPB_CRD_W = 12;
  localparam int unsigned VSPB_Y_LSB = 16;
  localparam int unsigned VSPB_X_LSB = 0;
  localparam int unsigned VSPB_KEY_W = 24;
  localparam int unsigned VSPB_MSK_UB_BIT = 24;
  localparam logic [1:0] VSPB_PAD = 2'h0;
endpackage : vspb_pkg
`default_nettype wire

// >>> vspb_cfg_if.sv
// Active configuration and derived results passed between plane modules
`timescale 1ns/1ns
`default_nettype none
interface vspb_cfg_if;
  logic [31:0] ctl;
  logic [31:0] key_val;
  logic [31:0] key_msk;
  logic [23:0] key_max;
  logic [31:0] pos;
  logic [31:0] size;
  logic [31:0] lin_off;
  logic [31:0] surf_base;
  logic [31:0] spr_word;
  logic spr_odd;
  logic [23:0] pipe_pix;
  logic [29:0] pix10;
  logic src_hit;
  logic dst_hit;
  logic csc_on;
  logic range_exp;
  logic mat_709;
  logic [12:0] eff_x;
  logic [12:0] eff_y;
  logic [12:0] eff_w;
  logic [12:0] eff_h;
  logic [31:0] first_addr;
  logic line_rep;
  logic scan_rev;
  modport core (output ctl, key_val, key_msk, key_max, pos, size, lin_off, surf_base,
    spr_word, spr_odd, pipe_pix, input pix10, src_hit, dst_hit, csc_on, range_exp,
    mat_709, eff_x, eff_y, eff_w, eff_h, first_addr, line_rep, scan_rev);
  modport pix (input ctl, key_val, key_msk, key_max, spr_word, spr_odd, pipe_pix,
    output pix10, src_hit, dst_hit, csc_on, range_exp, mat_709);
  modport geom (input ctl, pos, size, lin_off, surf_base,
    output eff_x, eff_y, eff_w, eff_h, first_addr, line_rep, scan_rev);
endinterface : vspb_cfg_if
`default_nettype wire

// >>> vspb_pix.sv
// Pixel unpack, 10-bit widening and colour key compare
`timescale 1ns/1ns
`default_nettype none
module vspb_pix
  import vspb_pkg::*;
(
  vspb_cfg_if.pix cfg
);
  logic [7:0] b0, b1, b2, b3;
  logic [7:0] y0, y1, u, v;
  logic rgb;
  logic xs512;
  logic [2:0][7:0] ch;
  logic [2:0] hit;

  assign b0 = cfg.spr_word[7:0];
  assign b1 = cfg.spr_word[15:8];
  assign b2 = cfg.spr_word[23:16];
  assign b3 = cfg.spr_word[31:24];
  assign rgb = cfg.ctl[VSPB_FMT_BIT];

  always_comb begin
    y0 = b0;
    u = b1;
    y1 = b2;
    v = b3;
    case (cfg.ctl[VSPB_ORD_LSB +: 2])
      VSPB_ORD_YUYV: begin
        y0 = b0; u = b1; y1 = b2; v = b3;
      end
      VSPB_ORD_UYVY: begin
        u = b0; y0 = b1; v = b2; y1 = b3;
      end
      VSPB_ORD_YVYU: begin
        y0 = b0; v = b1; y1 = b2; u = b3;
      end
      VSPB_ORD_VYUY: begin
        v = b0; y0 = b1; u = b2; y1 = b3;
      end
      default: begin
        y0 = b0; u = b1; y1 = b2; v = b3;
      end
    endcase
  end

  // Channel 2 is V or R, 1 is Y or G, 0 is U or B
  assign ch[2] = rgb ? b2 : v;
  assign ch[1] = rgb ? b1 : (cfg.spr_odd ? y1 : y0);
  assign ch[0] = rgb ? b0 : u;

  // excess-512 only on the bypass path of YUV data
  assign xs512 = ~rgb & cfg.ctl[VSPB_CSCOFF_BIT] & cfg.ctl[VSPB_XS512_BIT];

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_ch
      // chroma re-biased by flipping its sign bit; luma untouched
      // every channel widened to 10 bits
      assign cfg.pix10[10*i +: 10] = (xs512 && i != 1) ?
        {~ch[i][7], ch[i][6:0], VSPB_PAD} : {ch[i], VSPB_PAD};
      // range minimum for YUV, exact value for RGB
      assign hit[i] = ~cfg.key_msk[VSPB_MSK_UB_BIT + i] | (rgb ?
        (ch[i] == cfg.key_val[8*i +: 8]) :
        (ch[i] >= cfg.key_val[8*i +: 8] && ch[i] <= cfg.key_max[8*i +: 8]));
    end
  endgenerate

  // source key match makes the pixel transparent
  assign cfg.src_hit = cfg.ctl[VSPB_SRCKEY_BIT] & (&hit);
  // zero mask bits ignore mismatches in destination key
  assign cfg.dst_hit = cfg.ctl[VSPB_DSTKEY_BIT] &
    (((cfg.pipe_pix ^ cfg.key_val[VSPB_KEY_W-1:0]) & cfg.key_msk[VSPB_KEY_W-1:0]) ==
    VSPB_ZERO[VSPB_KEY_W-1:0]);
  // conversion controls, all dead for RGB sources
  assign cfg.csc_on = ~rgb & ~cfg.ctl[VSPB_CSCOFF_BIT];
  assign cfg.range_exp = ~rgb & ~cfg.ctl[VSPB_CSCOFF_BIT] & ~cfg.ctl[VSPB_RNGOFF_BIT];
  assign cfg.mat_709 = ~rgb & ~cfg.ctl[VSPB_CSCOFF_BIT] & cfg.ctl[VSPB_M709_BIT];
endmodule : vspb_pix
`default_nettype wire

// >>> vspb_geom.sv
// Plane geometry: duplication scaling and first pixel address
`timescale 1ns/1ns
`default_nettype none
module vspb_geom
  import vspb_pkg::*;
(
  vspb_cfg_if.geom cfg
);
  logic [1:0] dup;
  logic hdbl;
  logic vdbl;
  logic [VSPB_CRD_W-1:0] x, y, w, h;

  // field layout of position and size
  assign x = cfg.pos[VSPB_X_LSB +: VSPB_CRD_W];
  assign y = cfg.pos[VSPB_Y_LSB +: VSPB_CRD_W];
  assign w = cfg.size[VSPB_X_LSB +: VSPB_CRD_W];
  assign h = cfg.size[VSPB_Y_LSB +: VSPB_CRD_W];

  // reserved code 10 behaves as no duplication
  assign dup = cfg.ctl[VSPB_DUP_LSB +: 2];
  assign hdbl = (dup == VSPB_DUP_LP) || (dup == VSPB_DUP_PIX);
  assign vdbl = (dup == VSPB_DUP_LP);
  assign cfg.line_rep = vdbl;

  // doubled minus-one size is twice plus one
  assign cfg.eff_x = hdbl ? {x, 1'h0} : {1'h0, x};
  assign cfg.eff_w = hdbl ? {w, 1'h1} : {1'h0, w};
  assign cfg.eff_y = vdbl ? {y, 1'h0} : {1'h0, y};
  assign cfg.eff_h = vdbl ? {h, 1'h1} : {1'h0, h};

  // offset only counts for linear surfaces
  assign cfg.first_addr = cfg.surf_base +
    (cfg.ctl[VSPB_TILED_BIT] ? VSPB_ZERO : cfg.lin_off);
  // rotated scan walks back from the given corner
  assign cfg.scan_rev = cfg.ctl[VSPB_ROT_BIT];
endmodule : vspb_geom
`default_nettype wire

// >>> vspb_config_tb.sv
// Self-checking bench for the second sprite plane register set
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vspb_pkg::*;
  logic core_clk, reset, clk_en, reg_wr, reg_rd, surf_write, vblank, sprite_odd;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, surf_base, sprite_word, reg_rdata, active_control, active_stride;
  logic [31:0] active_key_value, active_key_mask, first_pixel_addr;
  logic [23:0] key_max, pipe_pixel;
  logic [12:0] eff_x, eff_y, eff_w, eff_h;
  logic [29:0] pixel_10b;
  logic reg_rvalid, line_repeat, scan_reverse, use_sprite, csc_on, range_expand;
  logic matrix_709, update_pending, plane_enabled;
  int mismatches = 0;
  int n_checks = 0;

  vspb_config dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .surf_write(surf_write),
    .surf_base(surf_base), .key_max(key_max), .vblank(vblank), .sprite_word(sprite_word),
    .sprite_odd(sprite_odd), .pipe_pixel(pipe_pixel), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .active_control(active_control), .active_stride(active_stride),
    .active_key_value(active_key_value), .active_key_mask(active_key_mask), .eff_x(eff_x),
    .eff_y(eff_y), .eff_w(eff_w), .eff_h(eff_h), .first_pixel_addr(first_pixel_addr),
    .line_repeat(line_repeat), .scan_reverse(scan_reverse), .pixel_10b(pixel_10b),
    .use_sprite(use_sprite), .csc_on(csc_on), .range_expand(range_expand),
    .matrix_709(matrix_709), .update_pending(update_pending), .plane_enabled(plane_enabled));

  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Synchronous reset held five cycles
  task automatic do_reset();
    @(negedge core_clk);
    reset = 1'b1;
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  // Read answer is due one cycle after the strobe; bounded wait guards a hang
  task automatic rdchk(input logic [19:0] a, input logic [31:0] exp);
    int n = 0;
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 4) begin
      mismatches++;
      $display("BAD rvalid expected 1 seen %b", reg_rvalid);
      summarize();
    end else begin
      chk("read_latency", 32'h0, n);
      chk("reg_rdata", exp, reg_rdata);
    end
  endtask : rdchk

  // Trigger then a vblank rising edge, leaving time for geometry to follow
  task automatic commit(input bit trig);
    if (trig) begin
      @(negedge core_clk);
      surf_write = 1'b1;
      @(negedge core_clk);
      surf_write = 1'b0;
    end
    @(negedge core_clk);
    vblank = 1'b1;
    repeat (2) @(negedge core_clk);
    vblank = 1'b0;
    @(negedge core_clk);
  endtask : commit

  task automatic pix(input logic [31:0] w, input logic [23:0] p);
    @(negedge core_clk);
    sprite_word = w;
    pipe_pixel = p;
    @(negedge core_clk);
  endtask : pix

  // Reset values, reserved bits and an unmapped address
  task automatic t_regs();
    logic [19:0] ad[7] = '{VSPB_OFF_CTL, VSPB_OFF_LINOFF, VSPB_OFF_STRIDE, VSPB_OFF_POS,
      VSPB_OFF_SIZE, VSPB_OFF_KVAL, VSPB_OFF_KMSK};
    logic [31:0] mk[7] = '{32'hDC7F8404, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0FFF0FFF,
      32'h0FFF0FFF, 32'h00FFFFFF, 32'h07FFFFFF};
    for (int i = 0; i < 7; i++) rdchk(ad[i], 32'h0);
    for (int i = 0; i < 7; i++) wr(ad[i], 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) rdchk(ad[i], mk[i]);
    wr(20'h731A8, 32'hFFFFFFFF);
    rdchk(20'h731A8, 32'h0);
    do_reset();
  endtask : t_regs

  // Double buffering: trigger, enable, always-loaded geometry, frozen clock
  task automatic t_dbuf();
    surf_base = 32'h00040000;
    wr(VSPB_OFF_CTL, 32'h80000000);
    chk("pending", 32'h1, update_pending);
    wr(VSPB_OFF_STRIDE, 32'h00001000);
    wr(VSPB_OFF_POS, 32'h00050003);
    wr(VSPB_OFF_SIZE, 32'h000F001F);
    wr(VSPB_OFF_LINOFF, 32'h00000100);
    chk("ctl_early", 32'h0, active_control);
    @(negedge core_clk);
    clk_en = 1'b0;
    vblank = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("ctl_frozen", 32'h0, active_control);
    clk_en = 1'b1;
    @(negedge core_clk);
    chk("active_control", 32'h80000000, active_control);
    chk("plane_enabled", 32'h1, plane_enabled);
    chk("active_stride", 32'h00001000, active_stride);
    chk("pending_clr", 32'h0, update_pending);
    @(negedge core_clk);
    vblank = 1'b0;
    chk("eff_x", 32'h3, eff_x);
    chk("eff_y", 32'h5, eff_y);
    chk("eff_w", 32'h1F, eff_w);
    chk("eff_h", 32'hF, eff_h);
    chk("first_addr", 32'h00040100, first_pixel_addr);
    wr(VSPB_OFF_STRIDE, 32'h00002000);
    wr(VSPB_OFF_POS, 32'h00070009);
    commit(1'b0);
    chk("stride_hold", 32'h00001000, active_stride);
    chk("eff_x_nt", 32'h9, eff_x);
    commit(1'b1);
    chk("stride_new", 32'h00002000, active_stride);
    wr(VSPB_OFF_CTL, 32'h0);
    commit(1'b0);
    chk("plane_off", 32'h0, plane_enabled);
    wr(VSPB_OFF_CTL, 32'h80008400);
    commit(1'b0);
    chk("tiled_addr", 32'h00040000, first_pixel_addr);
    chk("scan_reverse", 32'h1, scan_reverse);
  endtask : t_dbuf

  // Duplication codes scale position and size
  task automatic t_dup();
    logic [1:0] cd[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    logic [12:0] ex[4] = '{13'h3, 13'h6, 13'h6, 13'h3};
    logic [12:0] ey[4] = '{13'h5, 13'hA, 13'h5, 13'h5};
    logic [12:0] ew[4] = '{13'h1F, 13'h3F, 13'h3F, 13'h1F};
    logic [12:0] eh[4] = '{13'hF, 13'h1F, 13'hF, 13'hF};
    wr(VSPB_OFF_POS, 32'h00050003);
    for (int i = 0; i < 4; i++) begin
      wr(VSPB_OFF_CTL, {10'h200, cd[i], 20'h0});
      commit(1'b1);
      chk("dup_x", ex[i], eff_x);
      chk("dup_y", ey[i], eff_y);
      chk("dup_w", ew[i], eff_w);
      chk("dup_h", eh[i], eff_h);
      chk("line_repeat", cd[i] == 2'h1, line_repeat);
    end
  endtask : t_dup

  // Byte orders, conversion flags, excess-512 and test format
  task automatic t_pix();
    logic [7:0] ev[4] = '{8'h44, 8'h33, 8'h22, 8'h11};
    logic [7:0] ey[4] = '{8'h11, 8'h22, 8'h11, 8'h22};
    logic [7:0] eu[4] = '{8'h22, 8'h11, 8'h44, 8'h33};
    for (int i = 0; i < 4; i++) begin
      wr(VSPB_OFF_CTL, 32'h80000000 | (i[1] << 27) | (i[0] << 18) | (i << 16));
      commit(1'b1);
      pix(32'h44332211, 24'h0);
      chk("pix_yuv", {ev[i], 2'h0, ey[i], 2'h0, eu[i], 2'h0}, pixel_10b);
      chk("csc_on", 32'h1, csc_on);
      chk("range_expand", !i[1], range_expand);
      chk("matrix_709", i[0], matrix_709);
    end
    sprite_odd = 1'b1;
    pix(32'h44332211, 24'h0);
    chk("pix_odd", {8'h11, 2'h0, 8'h44, 2'h0, 8'h33, 2'h0}, pixel_10b);
    sprite_odd = 1'b0;
    wr(VSPB_OFF_CTL, 32'h90080000);
    commit(1'b1);
    pix(32'h44332211, 24'h0);
    chk("pix_xs512", {8'hC4, 2'h0, 8'h11, 2'h0, 8'hA2, 2'h0}, pixel_10b);
    chk("csc_bypass", 32'h0, csc_on);
    wr(VSPB_OFF_CTL, 32'h84040000);
    commit(1'b1);
    pix(32'h44332211, 24'h0);
    chk("pix_bgrx", {8'h33, 2'h0, 8'h22, 2'h0, 8'h11, 2'h0}, pixel_10b);
    chk("rgb_csc", 32'h0, csc_on);
    chk("rgb_709", 32'h0, matrix_709);
    chk("rgb_range", 32'h0, range_expand);
  endtask : t_pix

  // Source and destination colour keys
  task automatic t_key();
    wr(VSPB_OFF_CTL, 32'h84400000);
    wr(VSPB_OFF_KVAL, 32'h00332211);
    wr(VSPB_OFF_KMSK, 32'h07000000);
    commit(1'b1);
    pix(32'h44332211, 24'h0);
    chk("src_hit", 32'h0, use_sprite);
    pix(32'h44332212, 24'h0);
    chk("src_miss", 32'h1, use_sprite);
    wr(VSPB_OFF_CTL, 32'h80400000);
    commit(1'b1);
    pix(32'h44332222, 24'h0);
    chk("yuv_key_in", 32'h0, use_sprite);
    key_max = 24'h40FFFF;
    pix(32'h44332222, 24'h0);
    chk("yuv_key_max", 32'h1, use_sprite);
    key_max = 24'hFFFFFF;
    wr(VSPB_OFF_CTL, 32'h84000004);
    wr(VSPB_OFF_KVAL, 32'h00AABBCC);
    wr(VSPB_OFF_KMSK, 32'h0000FFFF);
    commit(1'b1);
    chk("key_mask", 32'h0000FFFF, active_key_mask);
    chk("key_value", 32'h00AABBCC, active_key_value);
    pix(32'h44332211, 24'h12BBCC);
    chk("dst_hit", 32'h1, use_sprite);
    pix(32'h44332211, 24'h12BBCD);
    chk("dst_miss", 32'h0, use_sprite);
  endtask : t_key

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 20'h0;
    reg_wdata = 32'h0;
    surf_write = 1'b0;
    surf_base = 32'h0;
    key_max = 24'hFFFFFF;
    vblank = 1'b0;
    sprite_word = 32'h0;
    sprite_odd = 1'b0;
    pipe_pixel = 24'h0;
    do_reset();
    t_regs();
    t_dbuf();
    t_dup();
    t_pix();
    t_key();
    summarize();
  end
endmodule : testbench
`default_nettype wire
